// ===== hw/rcf_flow_match.sv
`timescale 1ns/10ps
module rcf_flow_match
  import rcf_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // frames from the mac receive path
  input wire logic FRM_VALID,
  output logic FRM_READY,
  input wire rcf_frame_t FRM_DESC,
  // per-queue configuration
  input wire logic [NUM_Q-1:0] QUEUE_COALESCE_ENABLE,
  input wire logic [NUM_Q-1:0] INTERRUPT_GROUP_COALESCE_ENABLE,
  // queue abort requests
  input wire logic ABORT_VALID,
  input wire logic [Q_W-1:0] ABORT_QUEUE,
  input wire logic FUNCTION_LEVEL_RESET,
  // decisions to the receive dma
  output logic DEC_VALID,
  input wire logic DEC_READY,
  output rcf_action_t DEC_ACTION,
  output logic [CTX_W-1:0] DEC_CTX,
  output logic DEC_CLOSE_PREV,
  output logic DEC_CLOSE_AFTER,
  output logic [PKT_CNT_W-1:0] DEC_PKT_COUNT,
  output logic [Q_W-1:0] DEC_QUEUE,
  output logic [15:0] DEC_DESC_IDX,
  // context status
  output logic [NUM_CTX-1:0] ACTIVE_MASK
);

  rcf_stream_if #(.WIDTH($bits(rcf_frame_t))) in_q();
  rcf_stream_if #(.WIDTH($bits(rcf_frame_t))) out_q();

  // context table
  logic [NUM_CTX-1:0] ctx_valid;
  logic [HASH_W-1:0] ctx_hash [NUM_CTX];
  logic [TUPLE_W-1:0] ctx_tuple [NUM_CTX];
  logic [Q_W-1:0] ctx_queue [NUM_CTX];
  logic [7:0] ctx_hdr_off [NUM_CTX];
  logic ctx_ack [NUM_CTX];
  logic [1:0] ctx_ecn [NUM_CTX];
  logic [15:0] ctx_desc [NUM_CTX];
  logic [PKT_CNT_W-1:0] ctx_cnt [NUM_CTX];
  logic [STAMP_W-1:0] ctx_stamp [NUM_CTX];
  logic [STAMP_W-1:0] stamp_ctr;

  // decision register
  logic dec_valid;
  rcf_action_t dec_action;
  logic [CTX_W-1:0] dec_ctx;
  logic dec_close_prev;
  logic dec_close_after;
  logic [PKT_CNT_W-1:0] dec_cnt;
  logic [Q_W-1:0] dec_queue;
  logic [15:0] dec_desc;

  // combinational decision
  rcf_frame_t fr;
  logic take;
  logic candidate;
  logic [TUPLE_W-1:0] tuple;
  logic [HASH_W-1:0] hash;
  logic [NUM_CTX-1:0] abort_hit;
  logic any_hit;
  logic [CTX_W-1:0] hit_idx;
  logic any_free;
  logic [CTX_W-1:0] free_idx;
  logic [CTX_W-1:0] old_idx;
  logic [STAMP_W-1:0] old_age;
  logic append_ok;
  rcf_action_t next_action;
  logic [CTX_W-1:0] next_ctx;
  logic next_close_prev;
  logic next_close_after;
  logic [PKT_CNT_W-1:0] next_cnt;
  logic [15:0] next_desc;

  // input buffer between mac and the matcher
  assign in_q.valid = FRM_VALID;
  assign in_q.data = FRM_DESC;
  assign FRM_READY = in_q.ready;

  rcf_fifo #(.WIDTH($bits(rcf_frame_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(CLK),
    .rst(RST),
    .in_s(in_q),
    .out_s(out_q)
  );

  // one frame per cycle while the decision slot is free
  assign fr = rcf_frame_t'(out_q.data);
  assign take = out_q.valid && (!dec_valid || DEC_READY);
  assign out_q.ready = take;
  assign tuple = {fr.src_ip, fr.dst_ip, fr.src_port, fr.dst_port};
  assign hash = rcf_hash(tuple);

  // candidacy; the only length check is ip_len_short, which disqualifies, no upper length limit is applied
  always_comb
  begin
    candidate = QUEUE_COALESCE_ENABLE[fr.queue]
      && INTERRUPT_GROUP_COALESCE_ENABLE[fr.queue];
    if (fr.crc_err || fr.size_err || fr.mid_err || fr.code_err || fr.csum_err)
      candidate = 1'b0;
    if (fr.ip_len_short)
      candidate = 1'b0;
    if (!fr.tcp_ipv4 || fr.snap || fr.ipv6 || fr.tunnel)
      candidate = 1'b0;
    if (fr.ip_opts || fr.fragmented || fr.tcp_opts)
      candidate = 1'b0;
    if ((fr.tcp_flags & FLG_FORBIDDEN) != 12'h000)
      candidate = 1'b0;
    if (fr.ecn == ECN_BOTH_SET)
      candidate = 1'b0;
    if (fr.local_vm || (fr.replicated && !fr.on_src_queue))
      candidate = 1'b0;
  end

  // abort scope per context
  always_comb
  begin
    for (int i = 0; i < NUM_CTX; i++)
    begin
      abort_hit[i] = FUNCTION_LEVEL_RESET || (ABORT_VALID && ctx_queue[i] == ABORT_QUEUE);
    end
  end

  // hash search, free slot and oldest slot over all contexts
  always_comb
  begin
    any_hit = 1'b0;
    hit_idx = '0;
    any_free = 1'b0;
    free_idx = '0;
    old_idx = '0;
    old_age = '0;
    for (int i = NUM_CTX - 1; i >= 0; i--)
    begin
      if (ctx_valid[i] && ctx_hash[i] == hash)
      begin
        any_hit = 1'b1;
        hit_idx = CTX_W'(i);
      end
      if (!ctx_valid[i])
      begin
        any_free = 1'b1;
        free_idx = CTX_W'(i);
      end
    end
    for (int i = 0; i < NUM_CTX; i++)
    begin
      if (ctx_valid[i] && (stamp_ctr - ctx_stamp[i]) >= old_age)
      begin
        old_age = stamp_ctr - ctx_stamp[i];
        old_idx = CTX_W'(i);
      end
    end
  end

  // context state still fits the arriving segment
  assign append_ok = !fr.append_fail
    && ctx_queue[hit_idx] == fr.queue
    && ctx_hdr_off[hit_idx] == fr.hdr_off
    && ctx_ack[hit_idx] == fr.tcp_flags[FLG_ACK]
    && ctx_ecn[hit_idx] == fr.ecn;

  // action choice for the head frame
  always_comb
  begin
    next_action = RCF_OPEN;
    next_ctx = '0;
    next_close_prev = 1'b0;
    next_cnt = PKT_CNT_START;
    next_desc = fr.desc_idx;
    if (!candidate)
    begin
      next_action = RCF_LEGACY;
    end
    else if (any_hit && ctx_tuple[hit_idx] == tuple)
    begin
      next_ctx = hit_idx;
      if (append_ok)
      begin
        next_action = RCF_APPEND;
        if (!fr.new_desc)
        begin
          next_cnt = ctx_cnt[hit_idx] + 1'b1;
          next_desc = ctx_desc[hit_idx];
        end
      end
      else
      begin
        next_close_prev = 1'b1;
      end
    end
    else if (any_hit)
    begin
      next_ctx = hit_idx;
      next_close_prev = 1'b1;
    end
    else if (any_free)
    begin
      next_ctx = free_idx;
    end
    else
    begin
      next_ctx = old_idx;
      next_close_prev = 1'b1;
    end
    if (abort_hit[next_ctx])
      next_close_prev = 1'b0;
    next_close_after = (next_action != RCF_LEGACY)
      && (fr.tcp_flags[FLG_PSH] || next_cnt == PKT_CNT_LAST);
  end

  // open-order stamp for oldest selection
  always_ff @(posedge CLK)
  begin
    if (RST)
      stamp_ctr <= '0;
    else if (take && next_action == RCF_OPEN)
      stamp_ctr <= stamp_ctr + 1'b1;
  end

  // context valid bits; abort and reset win over any update
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      ctx_valid <= '0;
    end
    else
    begin
      if (take && next_action != RCF_LEGACY)
        ctx_valid[next_ctx] <= !next_close_after;
      for (int i = 0; i < NUM_CTX; i++)
      begin
        if (abort_hit[i])
          ctx_valid[i] <= 1'b0;
      end
    end
  end

  // context fields captured on open, dynamic ones on append
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      for (int i = 0; i < NUM_CTX; i++)
      begin
        ctx_hash[i] <= '0;
        ctx_tuple[i] <= '0;
        ctx_queue[i] <= '0;
        ctx_hdr_off[i] <= '0;
        ctx_ack[i] <= 1'b0;
        ctx_ecn[i] <= '0;
        ctx_desc[i] <= '0;
        ctx_cnt[i] <= '0;
        ctx_stamp[i] <= '0;
      end
    end
    else if (take && next_action == RCF_OPEN)
    begin
      ctx_hash[next_ctx] <= hash;
      ctx_tuple[next_ctx] <= tuple;
      ctx_queue[next_ctx] <= fr.queue;
      ctx_hdr_off[next_ctx] <= fr.hdr_off;
      ctx_ack[next_ctx] <= fr.tcp_flags[FLG_ACK];
      ctx_ecn[next_ctx] <= fr.ecn;
      ctx_desc[next_ctx] <= next_desc;
      ctx_cnt[next_ctx] <= next_cnt;
      ctx_stamp[next_ctx] <= stamp_ctr;
    end
    else if (take && next_action == RCF_APPEND)
    begin
      ctx_desc[next_ctx] <= next_desc;
      ctx_cnt[next_ctx] <= next_cnt;
    end
  end

  // decision register toward the dma
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      dec_valid <= 1'b0;
      dec_action <= RCF_LEGACY;
      dec_ctx <= '0;
      dec_close_prev <= 1'b0;
      dec_close_after <= 1'b0;
      dec_cnt <= '0;
      dec_queue <= '0;
      dec_desc <= '0;
    end
    else if (take)
    begin
      dec_valid <= 1'b1;
      dec_action <= next_action;
      dec_ctx <= next_ctx;
      dec_close_prev <= next_close_prev;
      dec_close_after <= next_close_after;
      dec_cnt <= (next_action == RCF_LEGACY) ? '0 : next_cnt;
      dec_queue <= fr.queue;
      dec_desc <= fr.desc_idx;
    end
    else if (DEC_READY)
    begin
      dec_valid <= 1'b0;
    end
  end

  // outputs
  assign DEC_VALID = dec_valid;
  assign DEC_ACTION = dec_action;
  assign DEC_CTX = dec_ctx;
  assign DEC_CLOSE_PREV = dec_close_prev;
  assign DEC_CLOSE_AFTER = dec_close_after;
  assign DEC_PKT_COUNT = dec_cnt;
  assign DEC_QUEUE = dec_queue;
  assign DEC_DESC_IDX = dec_desc;
  assign ACTIVE_MASK = ctx_valid;

endmodule // rcf_flow_match

// ===== hw/rcf_pkg.sv
package rcf_pkg;

  // context table geometry
  localparam int NUM_CTX = 32;
  localparam int CTX_W = 5;
  localparam int NUM_Q = 128;
  localparam int Q_W = 7;
  localparam int HASH_W = 8;
  localparam int TUPLE_W = 96;
  localparam int STAMP_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int PKT_CNT_W = 4;

  // packets-per-descriptor counter limits
  localparam logic [PKT_CNT_W-1:0] PKT_CNT_START = 4'h1;
  localparam logic [PKT_CNT_W-1:0] PKT_CNT_LAST = 4'hf;

  // ecn code that disqualifies a frame
  localparam logic [1:0] ECN_BOTH_SET = 2'h3;

  // tcp flag bit positions in the 12-bit flag field
  localparam int FLG_FIN = 0;
  localparam int FLG_SYN = 1;
  localparam int FLG_RST = 2;
  localparam int FLG_PSH = 3;
  localparam int FLG_ACK = 4;
  localparam int FLG_URG = 5;
  localparam int FLG_ECE = 6;
  localparam int FLG_CWR = 7;
  localparam int FLG_NS = 8;
  localparam int FLG_RSV_LO = 9;

  // every flag except psh and ack blocks coalescing
  localparam logic [11:0] FLG_FORBIDDEN = 12'hfe7;

  // parsed frame summary handed over by the mac receive path
  typedef struct packed {
    logic [31:0] src_ip;
    logic [31:0] dst_ip;
    logic [15:0] src_port;
    logic [15:0] dst_port;
    logic [Q_W-1:0] queue;
    logic [7:0] hdr_off;
    logic [15:0] desc_idx;
    logic new_desc;
    logic append_fail;
    logic [11:0] tcp_flags;
    logic [1:0] ecn;
    logic crc_err;
    logic size_err;
    logic mid_err;
    logic code_err;
    logic csum_err;
    logic ip_len_short;
    logic tcp_ipv4;
    logic snap;
    logic ipv6;
    logic tunnel;
    logic ip_opts;
    logic fragmented;
    logic tcp_opts;
    logic local_vm;
    logic replicated;
    logic on_src_queue;
  } rcf_frame_t;

  // what the downstream dma does with a frame
  typedef enum logic [1:0] {
    RCF_LEGACY,
    RCF_APPEND,
    RCF_OPEN
  } rcf_action_t;

  // xor fold of the four-tuple into a short hash
  function automatic logic [HASH_W-1:0] rcf_hash(input logic [TUPLE_W-1:0] t);
    logic [HASH_W-1:0] h;
    h = '0;
    for (int k = 0; k < TUPLE_W / HASH_W; k++)
    begin
      h = h ^ t[k*HASH_W +: HASH_W];
    end
    return h;
  endfunction

endpackage

// ===== hw/rcf_stream_if.sv
`timescale 1ns/10ps
interface rcf_stream_if #(parameter int WIDTH = 8);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport source(output valid, output data, input ready);
  modport sink(input valid, input data, output ready);
endinterface

// ===== hw/rcf_fifo.sv
`timescale 1ns/10ps
module rcf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fill and drain sides
  rcf_stream_if.sink in_s,
  rcf_stream_if.source out_s
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp;
  logic [AW:0] rp;
  logic full;
  logic empty;
  logic push;
  logic pop;

  // flags from pointer comparison
  assign full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
  assign empty = (wp == rp);
  assign in_s.ready = !full;
  assign out_s.valid = !empty;
  assign out_s.data = mem[rp[AW-1:0]];
  assign push = in_s.valid && !full;
  assign pop = out_s.ready && !empty;

  // write side
  always_ff @(posedge clk)
  begin
    if (rst)
      wp <= '0;
    else if (push)
      wp <= wp + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wp[AW-1:0]] <= in_s.data;
  end

  // read side
  always_ff @(posedge clk)
  begin
    if (rst)
      rp <= '0;
    else if (pop)
      rp <= rp + 1'b1;
  end

endmodule // rcf_fifo

// ===== testbench/rcf_flow_match_monitor.sv
`timescale 1ns/10ps
module rcf_flow_match_monitor
  import rcf_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // frame side and aborts
  input wire logic FRM_READY,
  input wire logic ABORT_VALID,
  input wire logic FUNCTION_LEVEL_RESET,
  // decision side
  input wire logic DEC_VALID,
  input wire logic DEC_READY,
  input wire rcf_action_t DEC_ACTION,
  input wire logic [CTX_W-1:0] DEC_CTX,
  input wire logic DEC_CLOSE_PREV,
  input wire logic DEC_CLOSE_AFTER,
  input wire logic [PKT_CNT_W-1:0] DEC_PKT_COUNT,
  input wire logic [NUM_CTX-1:0] ACTIVE_MASK
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  // handshake, decision encoding and context table relations
  property p_hold;
    DEC_VALID && !DEC_READY |=> DEC_VALID && $stable({DEC_ACTION, DEC_CTX, DEC_PKT_COUNT});
  endproperty
  property p_legacy;
    DEC_VALID && DEC_ACTION == RCF_LEGACY |-> DEC_CTX == 5'h00 && DEC_PKT_COUNT == 4'h0
      && !DEC_CLOSE_PREV && !DEC_CLOSE_AFTER;
  endproperty
  property p_open;
    DEC_VALID && DEC_ACTION == RCF_OPEN |-> DEC_PKT_COUNT == PKT_CNT_START;
  endproperty
  property p_last;
    DEC_VALID && DEC_PKT_COUNT == PKT_CNT_LAST |-> DEC_CLOSE_AFTER;
  endproperty
  property p_prev;
    DEC_VALID && DEC_CLOSE_PREV |-> DEC_ACTION == RCF_OPEN;
  endproperty
  property p_flr;
    FUNCTION_LEVEL_RESET |=> ACTIVE_MASK == 32'h0;
  endproperty
  property p_mask;
    $rose(DEC_VALID) && DEC_ACTION != RCF_LEGACY && !$past(ABORT_VALID)
      && !$past(FUNCTION_LEVEL_RESET) |-> ACTIVE_MASK[DEC_CTX] == !DEC_CLOSE_AFTER;
  endproperty
  property p_rst;
    $past(RST) |-> FRM_READY && !DEC_VALID && ACTIVE_MASK == 32'h0;
  endproperty
  a_hold: assert property (p_hold) else $error("decision moved in stall");
  a_legacy: assert property (p_legacy) else $error("legacy fields");
  a_open: assert property (p_open) else $error("open count");
  a_last: assert property (p_last) else $error("last count");
  a_prev: assert property (p_prev) else $error("close without open");
  a_flr: assert property (p_flr) else $error("flr left context");
  a_mask: assert property (p_mask) else $error("mask wrong");
  a_rst: assert property (p_rst) else $error("reset state");
  // main scenarios reached
  c_prev: cover property (DEC_VALID && DEC_CLOSE_PREV);
  c_push: cover property (DEC_VALID && DEC_CLOSE_AFTER && DEC_ACTION == RCF_APPEND);
  c_full: cover property (!FRM_READY);
endmodule // rcf_flow_match_monitor

bind rcf_flow_match rcf_flow_match_monitor u_mon (.CLK(CLK), .RST(RST), .FRM_READY(FRM_READY),
  .ABORT_VALID(ABORT_VALID), .FUNCTION_LEVEL_RESET(FUNCTION_LEVEL_RESET),
  .DEC_VALID(DEC_VALID), .DEC_READY(DEC_READY), .DEC_ACTION(DEC_ACTION), .DEC_CTX(DEC_CTX),
  .DEC_CLOSE_PREV(DEC_CLOSE_PREV), .DEC_CLOSE_AFTER(DEC_CLOSE_AFTER),
  .DEC_PKT_COUNT(DEC_PKT_COUNT), .ACTIVE_MASK(ACTIVE_MASK));

// ===== testbench/rcf_dma_model.sv
`timescale 1ns/10ps
module rcf_dma_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pacing from the bench
  input wire logic stall,
  input wire logic slow,
  // decision handshake
  input wire logic dec_valid,
  output logic dec_ready
);
  // slow mode drops ready after each taken decision
  always_ff @(posedge clk)
  begin
    if (rst)
      dec_ready <= 1'b0;
    else
      dec_ready <= !stall && !(slow && dec_ready && dec_valid);
  end
endmodule // rcf_dma_model

// ===== testbench/rcf_flow_match_tb.sv
`timescale 1ns/10ps
module rcf_flow_match_tb
  import rcf_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic frm_valid = 1'b0;
  logic frm_ready;
  rcf_frame_t frm_desc = '0;
  logic [NUM_Q-1:0] q_en = ~(128'h1 << 6);
  logic [NUM_Q-1:0] ig_en = ~(128'h1 << 7);
  logic abort_valid = 1'b0;
  logic [Q_W-1:0] abort_queue = 7'h05;
  logic flr = 1'b0;
  logic stall = 1'b0;
  logic slow = 1'b0;
  logic full_seen = 1'b0;
  logic dec_valid, dec_ready, close_prev, close_after;
  rcf_action_t action;
  logic [CTX_W-1:0] ctx;
  logic [PKT_CNT_W-1:0] cnt;
  logic [NUM_CTX-1:0] mask;
  logic [Q_W-1:0] dq_queue;
  logic [15:0] dq_desc;
  logic [12:0] dq[$];
  logic [22:0] dr[$];
  logic [22:0] sq[$];
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  rcf_frame_t f;

  always #20 clk = ~clk;

  rcf_flow_match DUT (.CLK(clk), .RST(rst), .FRM_VALID(frm_valid), .FRM_READY(frm_ready),
    .FRM_DESC(frm_desc), .QUEUE_COALESCE_ENABLE(q_en), .INTERRUPT_GROUP_COALESCE_ENABLE(ig_en),
    .ABORT_VALID(abort_valid), .ABORT_QUEUE(abort_queue), .FUNCTION_LEVEL_RESET(flr),
    .DEC_VALID(dec_valid), .DEC_READY(dec_ready), .DEC_ACTION(action), .DEC_CTX(ctx),
    .DEC_CLOSE_PREV(close_prev), .DEC_CLOSE_AFTER(close_after), .DEC_PKT_COUNT(cnt),
    .DEC_QUEUE(dq_queue), .DEC_DESC_IDX(dq_desc), .ACTIVE_MASK(mask));
  rcf_dma_model u_dma (.clk(clk), .rst(rst), .stall(stall), .slow(slow),
    .dec_valid(dec_valid), .dec_ready(dec_ready));

  // capture taken decisions, note refusals, cut hangs short
  always @(posedge clk)
  begin
    if (dec_valid === 1'b1 && dec_ready === 1'b1)
    begin
      dq.push_back({action, ctx, close_prev, close_after, cnt});
      dr.push_back({dq_queue, dq_desc});
    end
    if (frm_ready === 1'b0)
      full_seen = 1'b1;
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("tests %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // plain tcp/ipv4 candidate on queue 5
  function automatic rcf_frame_t fr(input logic [7:0] id);
    rcf_frame_t r;
    r = '0;
    r.src_ip = {24'h0a0000, id};
    r.dst_ip = 32'h0a000101;
    r.src_port = 16'h1234;
    r.dst_port = 16'h0050;
    r.desc_idx = {8'h5a, id};
    // queue 5 stands for a queue set up with advanced descriptors, crc strip
    // and a header buffer larger than any header
    r.queue = 7'h05;
    r.tcp_flags = 12'h010;
    r.tcp_ipv4 = 1'b1;
    return r;
  endfunction

  task automatic send(input rcf_frame_t fd);
    frm_desc = fd;
    frm_valid = 1'b1;
    sq.push_back({fd.queue, fd.desc_idx});
    while (frm_ready !== 1'b1) @(posedge clk) #1;
    @(posedge clk) #1;
  endtask

  task automatic expect_dec(input rcf_action_t a, input logic [4:0] c, input logic p,
    input logic af, input logic [3:0] n);
    int w;
    frm_valid = 1'b0;
    w = 0;
    while (dq.size() == 0 && w < 200)
    begin
      @(posedge clk) #1;
      w++;
    end
    check(dq.size() == 0 ? 32'hdead0000 : {19'h0, dq.pop_front()}, {19'h0, a, c, p, af, n});
    check(dr.size() == 0 ? 32'hdead0000 : {9'h0, dr.pop_front()}, {9'h0, sq.pop_front()});
  endtask

  task automatic clear();
    flr = 1'b1;
    @(posedge clk) #1;
    flr = 1'b0;
    check(mask, 32'h0);
  endtask

  task automatic t_candidacy();
    int fb[10] = '{FLG_FIN, FLG_SYN, FLG_RST, FLG_URG, FLG_ECE, FLG_CWR, FLG_NS,
      FLG_RSV_LO, FLG_RSV_LO + 1, FLG_RSV_LO + 2};
    slow = 1'b1;
    for (int i = 0; i < 28; i++)
    begin
      f = fr(8'h01);
      case (i)
        0: f.crc_err = 1'b1;
        1: f.size_err = 1'b1;
        2: f.mid_err = 1'b1;
        3: f.code_err = 1'b1;
        4: f.csum_err = 1'b1;
        5: f.ip_len_short = 1'b1;
        6: f.tcp_ipv4 = 1'b0;
        7: f.snap = 1'b1;
        8: f.ipv6 = 1'b1;
        9: f.tunnel = 1'b1;
        10: f.ip_opts = 1'b1;
        11: f.fragmented = 1'b1;
        12: f.tcp_opts = 1'b1;
        13: f.local_vm = 1'b1;
        14: f.replicated = 1'b1;
        15: f.ecn = ECN_BOTH_SET;
        16: f.queue = 7'h06;
        17: f.queue = 7'h07;
        default: f.tcp_flags[fb[i - 18]] = 1'b1;
      endcase
      send(f);
      expect_dec(RCF_LEGACY, 5'h00, 1'b0, 1'b0, 4'h0);
    end
    check(mask, 32'h0);
    slow = 1'b0;
    $display("end candidacy");
  endtask

  task automatic t_open_append();
    clear();
    f = fr(8'h02);
    f.replicated = 1'b1;
    f.on_src_queue = 1'b1;
    send(f);
    expect_dec(RCF_OPEN, 5'h00, 1'b0, 1'b0, 4'h1);
    send(f);
    expect_dec(RCF_APPEND, 5'h00, 1'b0, 1'b0, 4'h2);
    f.new_desc = 1'b1;
    send(f);
    expect_dec(RCF_APPEND, 5'h00, 1'b0, 1'b0, 4'h1);
    f.new_desc = 1'b0;
    f.tcp_flags[FLG_PSH] = 1'b1;
    send(f);
    expect_dec(RCF_APPEND, 5'h00, 1'b0, 1'b1, 4'h2);
    check(mask, 32'h0);
    f = fr(8'h03);
    send(f);
    expect_dec(RCF_OPEN, 5'h00, 1'b0, 1'b0, 4'h1);
    for (int i = 2; i < 16; i++)
    begin
      send(f);
      expect_dec(RCF_APPEND, 5'h00, 1'b0, i == 15, i[3:0]);
    end
    $display("end open_append");
  endtask

  task automatic t_fill();
    clear();
    stall = 1'b1;
    fork
      begin
        repeat (40) @(posedge clk);
        #1 stall = 1'b0;
      end
    join_none
    for (int i = 0; i < 32; i++)
      send(fr(8'h40 + i[7:0]));
    check(full_seen, 32'h1);
    for (int i = 0; i < 32; i++)
      expect_dec(RCF_OPEN, i[4:0], 1'b0, 1'b0, 4'h1);
    check(mask, 32'hffffffff);
    send(fr(8'h60));
    expect_dec(RCF_OPEN, 5'h00, 1'b1, 1'b0, 4'h1);
    $display("end fill");
  endtask

  task automatic t_collide_abort();
    clear();
    f = fr(8'h09);
    send(f);
    expect_dec(RCF_OPEN, 5'h00, 1'b0, 1'b0, 4'h1);
    f.append_fail = 1'b1;
    send(f);
    expect_dec(RCF_OPEN, 5'h00, 1'b1, 1'b0, 4'h1);
    f.append_fail = 1'b0;
    f.src_port = 16'h0050;
    f.dst_port = 16'h1234;
    send(f);
    expect_dec(RCF_OPEN, 5'h00, 1'b1, 1'b0, 4'h1);
    abort_queue = 7'h04;
    abort_valid = 1'b1;
    @(posedge clk) #1;
    check(mask, 32'h1);
    abort_queue = 7'h05;
    @(posedge clk) #1;
    abort_valid = 1'b0;
    check(mask, 32'h0);
    send(f);
    expect_dec(RCF_OPEN, 5'h00, 1'b0, 1'b0, 4'h1);
    // collision decided in the same cycle as an abort of its queue
    f.src_port = 16'h1234;
    f.dst_port = 16'h0050;
    send(f);
    frm_valid = 1'b0;
    abort_valid = 1'b1;
    @(posedge clk) #1;
    abort_valid = 1'b0;
    expect_dec(RCF_OPEN, 5'h00, 1'b0, 1'b0, 4'h1);
    check(mask, 32'h0);
    $display("end collide_abort");
  endtask

  // reset, then scenarios in turn
  initial
  begin
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    t_candidacy();
    t_open_append();
    t_fill();
    t_collide_abort();
    print_verdict();
  end
endmodule // rcf_flow_match_tb
